// file: dpa_map.svh
// Purpose: Offsets, field positions, reset values and sizes of the digital port block.
// Assumes: Included by the package and by the design modules by its bare name.
// Notes: Byte addresses on a 32-bit classic Wishbone bus; every register takes one word.
`ifndef DPA_MAP_SVH
`define DPA_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Sizes.
`define DPA_NUM_PORTS 4
`define DPA_PORT_W 8
`define DPA_ADR_W 8
`define DPA_DAT_W 32
`define DPA_PORT_D 3

////////////////////////////////////////////////////////////////////////////////
// Per-port register offsets inside a 16-byte port window.
`define DPA_OFS_PIN 4'h0
`define DPA_OFS_DIR 4'h4
`define DPA_OFS_LATCH 4'h8
`define DPA_OFS_BITOP 4'hC
`define DPA_PORT_AREA 2'h0

// Global registers.
`define DPA_ADR_MCU 8'h40
`define DPA_ADR_IRQ_STAT 8'h44
`define DPA_ADR_IRQ_MASK 8'h48

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define DPA_MCU_PULLOFF_BIT 4
`define DPA_BITOP_TGT_BIT 8
`define DPA_BITOP_VAL_BIT 9

// Port D alternate function pin positions and the pin change source count.
`define DPA_PD_RX0 0
`define DPA_PD_TX0 1
`define DPA_PD_RX1 2
`define DPA_PD_TX1 3
`define DPA_PD_CLK1 4
`define DPA_PCHG_CNT 5

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define DPA_RST_LATCH 8'h00
`define DPA_RST_DIR 8'h00
`define DPA_RST_MASK 32'h00000000

`endif

// file: dpa_pkg.sv
// Purpose: Types shared by the digital port block and its bus and interrupt helpers.
// Assumes: dpa_map.svh supplies every number used here.
// Notes: All carriers are packed so they can be registered as one word.
`include "dpa_map.svh"

package dpa_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // One bit per pin of every port.
  typedef logic [`DPA_NUM_PORTS-1:0][`DPA_PORT_W-1:0] dpa_ports_t;

  // Wishbone request as seen by the slave.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`DPA_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [`DPA_DAT_W-1:0] dat;
  } dpa_wb_req_t;

  // Requests from the serial units and timer 1 that override port D pins.
  typedef struct packed {
    logic serial0_tx_en;
    logic serial0_tx_line;
    logic serial0_rx_en;
    logic serial1_tx_en;
    logic serial1_tx_line;
    logic serial1_rx_en;
    logic serial1_sync;
    logic serial1_ext_clock;
    logic timer1_compare_b_en;
    logic timer1_compare_b_out;
  } dpa_alt_in_t;

  // Pin values handed to the peripherals and the interrupt logic.
  typedef struct packed {
    logic serial0_rx_line;
    logic serial1_rx_line;
    logic serial1_ext_clock_in;
    logic ext_irq_zero;
    logic ext_irq_one;
    logic timer3_count_input;
    logic [`DPA_PCHG_CNT-1:0] pin_change_src;
  } dpa_alt_out_t;

  ////////////////////////////////////////////////////////////////////////////////
  // State of the bus slave.
  typedef struct packed {
    logic ack;
  } dpa_wb_state_t;

  // State of the interrupt block.
  typedef struct packed {
    logic [`DPA_DAT_W-1:0] status;
    logic [`DPA_DAT_W-1:0] mask;
    logic irq;
  } dpa_irq_state_t;

  // State of the port block.
  typedef struct packed {
    dpa_ports_t latch;
    dpa_ports_t dir;
    dpa_ports_t pin_q;
    dpa_ports_t pad_out;
    dpa_ports_t pad_oe_b;
    dpa_ports_t pad_pull;
    logic pullup_global_off;
    logic primed;
    logic [`DPA_DAT_W-1:0] rdata;
    dpa_alt_out_t alt;
  } dpa_state_t;

endpackage : dpa_pkg

// file: dpa_wb_slave.sv
// Purpose: Classic Wishbone handshake for the port block.
// Assumes: The master holds its request until it samples ack high.
// Notes: Ack rises one edge after the request and falls on the next edge.
`timescale 1ns/1ps
`include "dpa_map.svh"

module dpa_wb_slave (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input dpa_pkg::dpa_wb_req_t req, // Bus request.
  output logic take, // Request accepted at this edge.
  output logic ack // Registered acknowledge.
);

  dpa_pkg::dpa_wb_state_t st;
  dpa_pkg::dpa_wb_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // A request is taken once; masking with ack stops a held request being taken twice.
  always_comb
  begin
    next_st = st;
    take = req.cyc & req.stb & ~st.ack;
    next_st.ack = take;
  end

  // Register the slave state.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ack = st.ack;

endmodule : dpa_wb_slave

// file: dpa_irq.sv
// Purpose: Sticky event status, mask and one level interrupt line.
// Assumes: clr is a one-cycle pulse from a read of the status register.
// Notes: An event in the clearing cycle survives the clear.
`timescale 1ns/1ps
`include "dpa_map.svh"

module dpa_irq #(
  parameter int W = `DPA_DAT_W
) (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic [W-1:0] evt, // One-cycle event pulses.
  input wire logic clr, // Clear all status bits.
  input wire logic [W-1:0] mask_we, // Per-bit write enable for the mask.
  input wire logic [W-1:0] mask_wd, // Mask write data.
  output logic [W-1:0] status, // Sticky status.
  output logic [W-1:0] mask, // Interrupt mask.
  output logic irq // Level interrupt, from a register.
);

  logic [W-1:0] st_status;
  logic [W-1:0] st_mask;
  logic st_irq;
  logic [W-1:0] next_status;
  logic [W-1:0] next_mask;
  logic next_irq;

  ////////////////////////////////////////////////////////////////////////////////
  // The set term is applied after the clear so a late event is never lost.
  always_comb
  begin
    next_status = (st_status & ~{W{clr}}) | evt;
    next_mask = (st_mask & ~mask_we) | (mask_wd & mask_we);
    next_irq = |(next_status & next_mask);
  end

  // Register status, mask and the interrupt line together.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_status <= '0;
      st_mask <= W'(`DPA_RST_MASK);
      st_irq <= 1'b0;
    end
    else
    begin
      st_status <= next_status;
      st_mask <= next_mask;
      st_irq <= next_irq;
    end
  end

  assign status = st_status;
  assign mask = st_mask;
  assign irq = st_irq;

endmodule : dpa_irq

// file: dpa_port_top.sv
// Purpose: General-purpose digital ports with port D alternate function overrides.
// Assumes: Pin inputs are synchronous to CLOCK; registers sit behind classic Wishbone.
// Notes: Pad outputs, enables and pull-ups are registered, so they follow a write by one edge.
//
// How it works
// - Each port has separate pin input, direction and output latch locations.
// - Pin input location stores nothing; latch and direction are read and write.
// - Writing ones to the pin input location toggles matching latch bits.
// - The global pull-up off bit disables every pull-up on every port.
// - Single bit set or clear touches only the addressed bit.
// - Each input pin has its own pull-up, enabled by its latch bit.
// - An alternate function on one pin leaves other pins as plain I/O.
// - Port D pin 4 carries timer 1 compare B only when set as output.
// - Port D pin 4 is serial 1 clock in sync mode; direction picks drive.
// - Serial 1 transmitter enabled forces port D pin 3 to output.
// - Serial 1 receiver enabled forces port D pin 2 input; latch keeps pull-up.
// - Serial 0 transmitter enabled forces port D pin 1 to output.
// - Serial 0 receiver enabled forces port D pin 0 input; latch keeps pull-up.
// - Port D pins 0 to 4 feed pin change sources 24 to 28.
// - Port D pin 3 is external interrupt 1, pin 2 external interrupt 0.
// - Port D pin 0 is the timer 3 external count input.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "dpa_map.svh"

module dpa_port_top (
  input wire logic CLOCK, // System clock, 50 MHz.
  input wire logic RST_B, // Synchronous reset, active low.
  input wire logic WB_CYC_I, // Wishbone cycle.
  input wire logic WB_STB_I, // Wishbone strobe.
  input wire logic WB_WE_I, // Wishbone write enable.
  input wire logic [`DPA_ADR_W-1:0] WB_ADR_I, // Wishbone byte address.
  input wire logic [3:0] WB_SEL_I, // Wishbone byte selects.
  input wire logic [`DPA_DAT_W-1:0] WB_DAT_I, // Wishbone write data.
  output logic [`DPA_DAT_W-1:0] WB_DAT_O, // Wishbone read data.
  output logic WB_ACK_O, // Wishbone acknowledge.
  output logic IRQ, // Pin change interrupt, active high level.
  input dpa_pkg::dpa_ports_t PIN_IN, // Sampled pin levels.
  output dpa_pkg::dpa_ports_t PIN_OUT, // Pin drive values.
  output dpa_pkg::dpa_ports_t PIN_OE_B, // Pin drive enables, active low.
  output dpa_pkg::dpa_ports_t PIN_PULLUP, // Pull-up enables, active high.
  input dpa_pkg::dpa_alt_in_t ALT_IN, // Peripheral override requests.
  output dpa_pkg::dpa_alt_out_t ALT_OUT // Pin values for peripherals.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  dpa_pkg::dpa_state_t st;
  dpa_pkg::dpa_state_t next_st;
  dpa_pkg::dpa_wb_req_t wb_req;
  dpa_pkg::dpa_ports_t eff_dir;
  dpa_pkg::dpa_ports_t eff_out;
  dpa_pkg::dpa_ports_t pin_evt;
  logic take;
  logic wr;
  logic rd;
  logic in_ports;
  logic [1:0] port_idx;
  logic [3:0] ofs;
  logic [`DPA_DAT_W-1:0] irq_status;
  logic [`DPA_DAT_W-1:0] irq_mask;
  logic [`DPA_DAT_W-1:0] mask_we;
  logic stat_clr;
  logic [`DPA_PORT_W-1:0] bit_mask;

  // Expand byte selects to a bit mask over the data word.
  function automatic logic [`DPA_DAT_W-1:0] sel_bits(input logic [3:0] sel);
    logic [`DPA_DAT_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : sel_bits

  // Set or clear the masked bits of one port register.
  function automatic logic [`DPA_PORT_W-1:0] bit_op(
    input logic [`DPA_PORT_W-1:0] cur,
    input logic [`DPA_PORT_W-1:0] m,
    input logic val
  );
    return val ? (cur | m) : (cur & ~m);
  endfunction : bit_op

  ////////////////////////////////////////////////////////////////////////////////
  // Bus request bundle and the handshake helper.
  assign wb_req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                    sel: WB_SEL_I, dat: WB_DAT_I};

  dpa_wb_slave u_wb (
    .clk(CLOCK),
    .rst_b(RST_B),
    .req(wb_req),
    .take(take),
    .ack(WB_ACK_O)
  );

  // Address split and access strobes for this cycle.
  assign wr = take & WB_WE_I;
  assign rd = take & ~WB_WE_I;
  assign in_ports = (WB_ADR_I[7:6] == `DPA_PORT_AREA);
  assign port_idx = WB_ADR_I[5:4];
  assign ofs = WB_ADR_I[3:0];
  assign stat_clr = rd & (WB_ADR_I == `DPA_ADR_IRQ_STAT);
  assign mask_we = (wr && WB_ADR_I == `DPA_ADR_IRQ_MASK) ? sel_bits(WB_SEL_I) : '0;
  assign bit_mask = WB_DAT_I[`DPA_PORT_W-1:0];

  // The first sample after reset has no previous value, so it raises no event.
  assign pin_evt = st.primed ? (PIN_IN ^ st.pin_q) : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin change events set sticky status bits; a status read clears them.
  dpa_irq #(
    .W(`DPA_DAT_W)
  ) u_irq (
    .clk(CLOCK),
    .rst_b(RST_B),
    .evt(pin_evt),
    .clr(stat_clr),
    .mask_we(mask_we),
    .mask_wd(WB_DAT_I),
    .status(irq_status),
    .mask(irq_mask),
    .irq(IRQ)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes, read data, pad resolution and alternate function taps.
  always_comb
  begin
    next_st = st;
    eff_dir = '0;
    eff_out = '0;
    next_st.pin_q = PIN_IN;
    next_st.primed = 1'b1;

    // Register writes; each location is decoded on its own.
    if (wr && in_ports && WB_SEL_I[0])
    begin
      case (ofs)
        `DPA_OFS_PIN:
        begin
          next_st.latch[port_idx] = st.latch[port_idx] ^ bit_mask;
        end
        `DPA_OFS_DIR:
        begin
          next_st.dir[port_idx] = bit_mask;
        end
        `DPA_OFS_LATCH:
        begin
          next_st.latch[port_idx] = bit_mask;
        end
        `DPA_OFS_BITOP:
        begin
          // Only masked bits move, so other pins keep their setting.
          if (WB_SEL_I[1])
          begin
            if (WB_DAT_I[`DPA_BITOP_TGT_BIT])
            begin
              next_st.latch[port_idx] = bit_op(st.latch[port_idx], bit_mask,
                                               WB_DAT_I[`DPA_BITOP_VAL_BIT]);
            end
            else
            begin
              next_st.dir[port_idx] = bit_op(st.dir[port_idx], bit_mask,
                                             WB_DAT_I[`DPA_BITOP_VAL_BIT]);
            end
          end
        end
        default:
        begin
          next_st.latch = st.latch;
        end
      endcase
    end
    if (wr && WB_ADR_I == `DPA_ADR_MCU && WB_SEL_I[0])
    begin
      next_st.pullup_global_off = WB_DAT_I[`DPA_MCU_PULLOFF_BIT];
    end

    // Read data; unmapped addresses and the bit-op location read as zero.
    if (rd)
    begin
      next_st.rdata = '0;
      if (in_ports)
      begin
        case (ofs)
          `DPA_OFS_PIN:
          begin
            next_st.rdata[`DPA_PORT_W-1:0] = st.pin_q[port_idx];
          end
          `DPA_OFS_DIR:
          begin
            next_st.rdata[`DPA_PORT_W-1:0] = st.dir[port_idx];
          end
          `DPA_OFS_LATCH:
          begin
            next_st.rdata[`DPA_PORT_W-1:0] = st.latch[port_idx];
          end
          default:
          begin
            next_st.rdata = '0;
          end
        endcase
      end
      else
      begin
        case (WB_ADR_I)
          `DPA_ADR_MCU:
          begin
            next_st.rdata[`DPA_MCU_PULLOFF_BIT] = st.pullup_global_off;
          end
          `DPA_ADR_IRQ_STAT:
          begin
            next_st.rdata = irq_status;
          end
          `DPA_ADR_IRQ_MASK:
          begin
            next_st.rdata = irq_mask;
          end
          default:
          begin
            next_st.rdata = '0;
          end
        endcase
      end
    end

    // Plain I/O for every pin first; overrides below touch single port D bits only.
    eff_dir = next_st.dir;
    eff_out = next_st.latch;

    // Serial 0 receiver forces its pin to input.
    if (ALT_IN.serial0_rx_en)
    begin
      eff_dir[`DPA_PORT_D][`DPA_PD_RX0] = 1'b0;
    end
    // Serial 0 transmitter owns its pin regardless of direction.
    if (ALT_IN.serial0_tx_en)
    begin
      eff_dir[`DPA_PORT_D][`DPA_PD_TX0] = 1'b1;
      eff_out[`DPA_PORT_D][`DPA_PD_TX0] = ALT_IN.serial0_tx_line;
    end
    // Serial 1 receiver forces its pin to input.
    if (ALT_IN.serial1_rx_en)
    begin
      eff_dir[`DPA_PORT_D][`DPA_PD_RX1] = 1'b0;
    end
    // Serial 1 transmitter owns its pin regardless of direction.
    if (ALT_IN.serial1_tx_en)
    begin
      eff_dir[`DPA_PORT_D][`DPA_PD_TX1] = 1'b1;
      eff_out[`DPA_PORT_D][`DPA_PD_TX1] = ALT_IN.serial1_tx_line;
    end
    // Pin 4: the sync serial clock wins over the compare output when both ask.
    if (ALT_IN.serial1_sync)
    begin
      if (next_st.dir[`DPA_PORT_D][`DPA_PD_CLK1])
      begin
        eff_out[`DPA_PORT_D][`DPA_PD_CLK1] = ALT_IN.serial1_ext_clock;
      end
    end
    else if (ALT_IN.timer1_compare_b_en && next_st.dir[`DPA_PORT_D][`DPA_PD_CLK1])
    begin
      eff_out[`DPA_PORT_D][`DPA_PD_CLK1] = ALT_IN.timer1_compare_b_out;
    end

    // Pull-up needs an input pin, a set latch bit and no global disable.
    next_st.pad_oe_b = ~eff_dir;
    next_st.pad_out = eff_out;
    next_st.pad_pull = ~eff_dir & next_st.latch
                       & {(`DPA_NUM_PORTS*`DPA_PORT_W){~next_st.pullup_global_off}};

    // Port D pin taps for the peripherals and the interrupt controller.
    next_st.alt.pin_change_src = PIN_IN[`DPA_PORT_D][`DPA_PCHG_CNT-1:0];
    next_st.alt.ext_irq_zero = PIN_IN[`DPA_PORT_D][`DPA_PD_RX1];
    next_st.alt.ext_irq_one = PIN_IN[`DPA_PORT_D][`DPA_PD_TX1];
    next_st.alt.timer3_count_input = PIN_IN[`DPA_PORT_D][`DPA_PD_RX0];
    next_st.alt.serial0_rx_line = PIN_IN[`DPA_PORT_D][`DPA_PD_RX0];
    next_st.alt.serial1_rx_line = PIN_IN[`DPA_PORT_D][`DPA_PD_RX1];
    next_st.alt.serial1_ext_clock_in = ALT_IN.serial1_sync
                                       & ~next_st.dir[`DPA_PORT_D][`DPA_PD_CLK1]
                                       & PIN_IN[`DPA_PORT_D][`DPA_PD_CLK1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register the whole state; reset leaves every pin an undriven input, no pull-up.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      st <= '0;
      st.latch <= {`DPA_NUM_PORTS{`DPA_RST_LATCH}};
      st.dir <= {`DPA_NUM_PORTS{`DPA_RST_DIR}};
      st.pad_oe_b <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flip-flops.
  assign WB_DAT_O = st.rdata;
  assign PIN_OUT = st.pad_out;
  assign PIN_OE_B = st.pad_oe_b;
  assign PIN_PULLUP = st.pad_pull;
  assign ALT_OUT = st.alt;

endmodule : dpa_port_top

// file: dpa_port_monitor.sv
// Purpose: Port-level checks on the digital port block.
// Assumes: One clock domain; RST_B is synchronous and active low.
// Notes: Sees only top-level ports, so register state is judged through the pads.
`timescale 1ns/1ps
`include "dpa_map.svh"

module dpa_port_monitor (
  input wire logic CLOCK, // System clock.
  input wire logic RST_B, // Reset, active low.
  input wire logic WB_CYC_I, // Bus cycle.
  input wire logic WB_STB_I, // Bus strobe.
  input logic WB_ACK_O, // Bus acknowledge.
  input dpa_pkg::dpa_ports_t PIN_IN, // Pin levels.
  input dpa_pkg::dpa_ports_t PIN_OUT, // Pin drive values.
  input dpa_pkg::dpa_ports_t PIN_OE_B, // Drive enables, active low.
  input dpa_pkg::dpa_ports_t PIN_PULLUP, // Pull-up enables.
  input dpa_pkg::dpa_alt_in_t ALT_IN, // Override requests.
  input dpa_pkg::dpa_alt_out_t ALT_OUT // Peripheral pin values.
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  ////////////////////////////////////////
  // Pads leave reset undriven, low and without pull-ups.
  property p_reset_pads;
    $rose(RST_B) |-> (&PIN_OE_B) && (PIN_PULLUP == '0) && (PIN_OUT == '0);
  endproperty
  a_reset_pads: assert property (p_reset_pads)
    else $error("pads not idle after reset");

  // A driven pin must never also pull up, or the pad fights itself.
  property p_pull_drive;
    (PIN_PULLUP & ~PIN_OE_B) == '0;
  endproperty
  a_pull_drive: assert property (p_pull_drive)
    else $error("pull-up on a driven pin");

  // Transmitters take their pins one edge after enable, whatever the direction.
  property p_tx1;
    ALT_IN.serial1_tx_en |=> !PIN_OE_B[3][3] && PIN_OUT[3][3] == $past(ALT_IN.serial1_tx_line);
  endproperty
  a_tx1: assert property (p_tx1)
    else $error("serial 1 transmit pin not driven");

  property p_tx0;
    ALT_IN.serial0_tx_en |=> !PIN_OE_B[3][1] && PIN_OUT[3][1] == $past(ALT_IN.serial0_tx_line);
  endproperty
  a_tx0: assert property (p_tx0)
    else $error("serial 0 transmit pin not driven");

  // Receivers release their pins one edge after enable.
  property p_rx1;
    ALT_IN.serial1_rx_en |=> PIN_OE_B[3][2];
  endproperty
  a_rx1: assert property (p_rx1)
    else $error("serial 1 receive pin still driven");

  property p_rx0;
    ALT_IN.serial0_rx_en |=> PIN_OE_B[3][0];
  endproperty
  a_rx0: assert property (p_rx0)
    else $error("serial 0 receive pin still driven");

  // Peripheral taps show the pins sampled at the previous edge.
  property p_taps;
    RST_B |=> ALT_OUT.pin_change_src == $past(PIN_IN[3][4:0])
      && ALT_OUT.ext_irq_zero == $past(PIN_IN[3][2]) && ALT_OUT.ext_irq_one == $past(PIN_IN[3][3])
      && ALT_OUT.timer3_count_input == $past(PIN_IN[3][0]);
  endproperty
  a_taps: assert property (p_taps)
    else $error("peripheral pin taps wrong");

  // Every taken request is answered by exactly one acknowledge cycle.
  property p_ack;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge not a one-cycle answer");
endmodule : dpa_port_monitor

bind dpa_port_top dpa_port_monitor i_dpa_port_monitor (
  .CLOCK(CLOCK),
  .RST_B(RST_B),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O),
  .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT),
  .PIN_OE_B(PIN_OE_B),
  .PIN_PULLUP(PIN_PULLUP),
  .ALT_IN(ALT_IN),
  .ALT_OUT(ALT_OUT)
);

// file: dpa_pin_model.sv
// Purpose: Board circuitry on the port pins.
// Assumes: Every pin has a weak board pull-down.
// Notes: The board driver is for inputs only; the device driver always wins.
`timescale 1ns/1ps

module dpa_pin_model (
  input dpa_pkg::dpa_ports_t pin_out, // Device drive values.
  input dpa_pkg::dpa_ports_t pin_oe_b, // Device drive enables, active low.
  input dpa_pkg::dpa_ports_t pin_pullup, // Device pull-ups.
  input dpa_pkg::dpa_ports_t ext_en, // Board drive enables.
  input dpa_pkg::dpa_ports_t ext_val, // Board drive values.
  output dpa_pkg::dpa_ports_t pin_level // Resolved levels.
);
  ////////////////////////////////////////
  // A released pin with no board drive and no pull-up falls to the pull-down, so it never keeps a stale value.
  assign pin_level = (~pin_oe_b & pin_out) | (pin_oe_b & ext_en & ext_val)
    | (pin_oe_b & ~ext_en & pin_pullup);
endmodule : dpa_pin_model

// file: dpa_port_top_tb.sv
// Purpose: Self-checking bench of the digital port block.
// Assumes: Wishbone answers within 20 cycles.
// Notes: Port D is index 3; the board model resolves pin levels.
`timescale 1ns/1ps

module dpa_port_top_tb;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_I = 32'h00000000;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic IRQ;
  dpa_pkg::dpa_ports_t PIN_IN, PIN_OUT, PIN_OE_B, PIN_PULLUP;
  dpa_pkg::dpa_ports_t ext_en = '0;
  dpa_pkg::dpa_ports_t ext_val = '0;
  dpa_pkg::dpa_alt_in_t ALT_IN = '0;
  dpa_pkg::dpa_alt_out_t ALT_OUT;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] q;

  always #10 CLOCK = ~CLOCK;

  dpa_port_top i_dpa_port_top (.CLOCK(CLOCK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_B(PIN_OE_B), .PIN_PULLUP(PIN_PULLUP),
    .ALT_IN(ALT_IN), .ALT_OUT(ALT_OUT));
  dpa_pin_model i_dpa_pin_model (.pin_out(PIN_OUT), .pin_oe_b(PIN_OE_B),
    .pin_pullup(PIN_PULLUP), .ext_en(ext_en), .ext_val(ext_val), .pin_level(PIN_IN));

  ////////////////////////////////////////
  // Verdict and end of run.
  task automatic summarize;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // One comparison, counted.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One classic cycle; waits for ack rather than assuming a latency.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge CLOCK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= dat;
    do
    begin
      @(posedge CLOCK);
      n++;
    end
    while (WB_ACK_O !== 1'b1 && n < 20);
    chk(32'(WB_ACK_O), 32'h1, "ack");
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
    wb(1'b0, adr, 32'h0);
    chk(q, exp, what);
  endtask : rd

  // Waits on the falling edge so registered outputs have settled.
  task automatic wt(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : wt

  task automatic set_alt(input dpa_pkg::dpa_alt_in_t v);
    @(posedge CLOCK);
    ALT_IN <= v;
    wt(2);
  endtask : set_alt

  ////////////////////////////////////////
  task automatic t_reset;
    chk(PIN_OE_B, 32'hFFFFFFFF, "oe after reset");
    chk(PIN_PULLUP, 32'h0, "pull after reset");
    for (int p = 0; p < 4; p++)
    begin
      rd(8'(p * 16 + 4), 32'h0, "dir reset");
      rd(8'(p * 16 + 8), 32'h0, "latch reset");
    end
    wb(1'b1, 8'h80, 32'hFF);
    rd(8'h80, 32'h0, "unmapped");
  endtask : t_reset

  // Port 1: outputs A5, latch 3C then toggled to 33; inputs pull up where latch is 1.
  task automatic t_port;
    wb(1'b1, 8'h14, 32'hA5);
    wb(1'b1, 8'h18, 32'h3C);
    rd(8'h14, 32'hA5, "dir");
    rd(8'h18, 32'h3C, "latch");
    wb(1'b1, 8'h10, 32'h0F);
    rd(8'h18, 32'h33, "toggle");
    rd(8'h10, 32'h33, "pins");
    chk(32'(PIN_PULLUP[1]), 32'h12, "pull");
    wb(1'b1, 8'h40, 32'h10);
    chk(PIN_PULLUP, 32'h0, "pull off");
    rd(8'h10, 32'h21, "pins pull off");
    wb(1'b1, 8'h40, 32'h0);
    chk(32'(PIN_PULLUP[1]), 32'h12, "pull back");
  endtask : t_port

  // Port 2: set latch bit 6 and clear direction bit 4 by bit operations.
  task automatic t_bitop;
    wb(1'b1, 8'h24, 32'hF0);
    wb(1'b1, 8'h28, 32'h0F);
    wb(1'b1, 8'h2C, 32'h340);
    wb(1'b1, 8'h2C, 32'h010);
    rd(8'h28, 32'h4F, "set latch bit");
    rd(8'h24, 32'hE0, "clear dir bit");
    rd(8'h2C, 32'h0, "bit op reads 0");
    chk(32'(PIN_OE_B[2]), 32'h1F, "oe port 2");
  endtask : t_bitop

  // Port D overrides against plain direction settings.
  task automatic t_alt;
    dpa_pkg::dpa_alt_in_t a;
    a = '0;
    wb(1'b1, 8'h34, 32'h00);
    wb(1'b1, 8'h38, 32'h05);
    a.serial1_tx_en = 1'b1;
    a.serial1_tx_line = 1'b1;
    a.serial0_tx_en = 1'b1;
    set_alt(a);
    chk(32'(PIN_OE_B[3]), 32'hF5, "tx oe");
    chk(32'(PIN_OUT[3]), 32'h0D, "tx out");
    wb(1'b1, 8'h34, 32'hE5);
    a.serial1_rx_en = 1'b1;
    a.serial0_rx_en = 1'b1;
    set_alt(a);
    chk(32'(PIN_OE_B[3]), 32'h15, "rx oe");
    chk(32'(PIN_PULLUP[3]), 32'h05, "rx pull");
    a = '0;
    a.serial1_sync = 1'b1;
    a.serial1_ext_clock = 1'b1;
    wb(1'b1, 8'h34, 32'h10);
    set_alt(a);
    chk(32'(PIN_OE_B[3]), 32'hEF, "clock out oe");
    chk(32'(PIN_OUT[3]), 32'h15, "clock out");
    wb(1'b1, 8'h34, 32'h00);
    @(posedge CLOCK);
    ext_en[3][4] <= 1'b1;
    ext_val[3][4] <= 1'b1;
    wt(3);
    chk(32'(ALT_OUT.serial1_ext_clock_in), 32'h1, "clock in");
    a = '0;
    a.timer1_compare_b_en = 1'b1;
    a.timer1_compare_b_out = 1'b1;
    set_alt(a);
    chk(32'(PIN_OE_B[3]), 32'hFF, "compare needs output");
    wb(1'b1, 8'h34, 32'h10);
    chk(32'(PIN_OE_B[3]), 32'hEF, "compare oe");
    chk(32'(PIN_OUT[3]), 32'h15, "compare out");
    ext_en[3][4] <= 1'b0;
    set_alt('0);
  endtask : t_alt

  // Pin change on port D pin 0 raises the masked interrupt; pins 2 and 3 stay masked.
  task automatic t_irq;
    wb(1'b1, 8'h34, 32'h00);
    wb(1'b1, 8'h38, 32'h00);
    wb(1'b1, 8'h48, 32'h01000000);
    wb(1'b0, 8'h44, 32'h0);
    wt(2);
    chk(32'(IRQ), 32'h0, "irq idle");
    @(posedge CLOCK);
    ext_en[3][3:0] <= 4'hD;
    ext_val[3][0] <= 1'b1;
    wt(2);
    chk(32'(IRQ), 32'h1, "irq raised");
    chk(32'(ALT_OUT.pin_change_src), 32'h01, "change src");
    chk(32'(ALT_OUT.timer3_count_input), 32'h1, "count in");
    chk(32'(ALT_OUT.serial0_rx_line), 32'h1, "rx0 in");
    rd(8'h44, 32'h01000000, "status");
    wt(2);
    chk(32'(IRQ), 32'h0, "irq cleared");
    @(posedge CLOCK);
    ext_val[3][3:2] <= 2'h3;
    wt(2);
    chk(32'(ALT_OUT.ext_irq_zero), 32'h1, "ext zero");
    chk(32'(ALT_OUT.serial1_rx_line), 32'h1, "rx1 in");
    chk(32'(ALT_OUT.ext_irq_one), 32'h1, "ext one");
    chk(32'(IRQ), 32'h0, "masked change");
  endtask : t_irq

  ////////////////////////////////////////
  // Reset for 20 cycles, then every scenario in turn.
  initial
  begin
    repeat (20) @(posedge CLOCK);
    RST_B <= 1'b1;
    t_reset();
    t_port();
    t_bitop();
    t_alt();
    t_irq();
    summarize();
  end

  // A hang ends the run as a failure.
  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      summarize();
    end
  end
endmodule : dpa_port_top_tb
